// ==== hw/ring_buffer_dma_handshake.sv ====
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
// Behaviour
// - Post trigger 16 to 8G-16, step 16
// - Pre trigger segment minus post, max 8k
// - Limits fixed; memory divider scales only FIFO capacity and fill level
// - Sample memory shifted right by the memory divider acts as FIFO
// - DMA moves words without host help
// - User length read returns available bytes
// - User position read returns region start
// - Card length write frees bytes for card
// - Separate user and card byte counters
// - To card: user length is empty space
// - To host: user length is new data
// - Fill level permille in sixteenth steps
// - Start: user zero, card full length
// - User bytes announced in notify multiples
// - Position wraps; length spans the wrap
// - Overrun drains then stops; underrun stops at once; both flag
module ring_buffer_dma_handshake
    import ring_dma_pkg::*;
#(
    parameter int MEM_W = 36,
    parameter int BEAT_BYTES = 8,
    parameter logic [MEM_W-1:0] MEM_SAMPLES = MEM_DEFAULT
)
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    // Register port
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic [DATA_W-1:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [DATA_W-1:0] rdata_out,
    // Sample side of the on-board FIFO
    input wire logic sample_push_in,
    input wire logic sample_pop_in,
    // DMA beat engine
    output logic dma_req_out,
    input wire logic dma_done_in,
    // Notification and status
    output logic notify_out,
    output logic running_out,
    output logic error_out
);
    typedef struct packed {
        run_state_t st;
        logic dir_to_card;
        logic [1:0] mode;
        logic [CNT_W-1:0] buf_len;
        logic [CNT_W-1:0] notify;
        logic [CNT_W-1:0] user_len;
        logic [CNT_W-1:0] pend;
        logic [CNT_W-1:0] card_len;
        logic [CNT_W-1:0] user_pos;
        logic [MEM_W-1:0] fifo_fill;
        logic [MEM_W-1:0] pre_trig;
        logic [MEM_W-1:0] post_trig;
        logic [MEM_W-1:0] segment;
        logic [1:0] mem_div;
        logic overrun;
        logic underrun;
        logic release_err;
        logic limit_err;
        logic notify_p;
        logic [DATA_W-1:0] rdata;
    } hs_state_t;

    hs_state_t s_q;
    hs_state_t s_d;
    logic [FILL_W-1:0] fill_level;
    logic [MEM_W-1:0] mem_eff;
    logic [9:0] idx;
    logic [CNT_W-1:0] rel;
    logic [CNT_W-1:0] pos_sum;
    logic beat_ok;
    logic fifo_full;
    logic fifo_empty;

    localparam logic [CNT_W-1:0] BEAT = CNT_W'(BEAT_BYTES);

    function automatic logic step_ok(input logic [MEM_W-1:0] v);
        step_ok = (v[3:0] == 4'h0);
    endfunction

    function automatic logic post_ok(input logic [MEM_W-1:0] v);
        post_ok = step_ok(v) && v >= POST_MIN && v <= POST_MAX;
    endfunction

    function automatic logic [MEM_W-1:0] pre_of(input logic [MEM_W-1:0] seg,
                                                 input logic [MEM_W-1:0] post);
        pre_of = (seg > post) ? seg - post : '0;
    endfunction

    function automatic logic [CNT_W-1:0] wrap_add(input logic [CNT_W-1:0] a,
                                                  input logic [CNT_W-1:0] b,
                                                  input logic [CNT_W-1:0] len);
        logic [CNT_W:0] sum;
        sum = {1'b0, a} + {1'b0, b};
        if (sum >= {1'b0, len})
        begin
            sum = sum - {1'b0, len};
        end
        wrap_add = sum[CNT_W-1:0];
    endfunction

    assign idx = addr_in[ADDR_W-1:2];
    assign mem_eff = MEM_SAMPLES >> s_q.mem_div;
    assign rel = wdata_in[CNT_W-1:0];
    assign pos_sum = wrap_add(s_q.user_pos, rel, s_q.buf_len);
    assign fifo_full = (s_q.fifo_fill >= mem_eff);
    assign fifo_empty = (s_q.fifo_fill == '0);
    assign beat_ok = (s_q.card_len >= BEAT) && (s_q.dir_to_card ? 1'b1 : !fifo_empty);

    always_comb
    begin
        s_d = s_q;
        s_d.notify_p = 1'b0;
        s_d.rdata = '0;

        // ******************************************************************
        // FIFO fill tracking
        // ******************************************************************
        if (s_q.st != ST_IDLE_S)
        begin
            if (!s_q.dir_to_card)
            begin
                if (sample_push_in && fifo_full)
                begin
                    s_d.overrun = 1'b1;
                    s_d.st = ST_DRAIN_S;
                end
                else if (sample_push_in && s_q.st == ST_MOVE_S)
                begin
                    s_d.fifo_fill = s_d.fifo_fill + MEM_W'(1);
                end
            end
            else if (sample_pop_in)
            begin
                if (fifo_empty)
                begin
                    s_d.underrun = 1'b1;
                    s_d.st = ST_IDLE_S;
                end
                else
                begin
                    s_d.fifo_fill = s_d.fifo_fill - MEM_W'(1);
                end
            end
        end

        // ******************************************************************
        // DMA beat completion
        // ******************************************************************
        // automatic beat moves
        if (dma_done_in && s_q.st != ST_IDLE_S && beat_ok)
        begin
            s_d.card_len = s_d.card_len - BEAT;
            if (s_q.dir_to_card)
            begin
                s_d.fifo_fill = s_d.fifo_fill + MEM_W'(1);
            end
            else
            begin
                s_d.fifo_fill = s_d.fifo_fill - MEM_W'(1);
            end
            if (s_q.pend + BEAT >= s_q.notify)
            begin
                s_d.user_len = s_q.user_len + s_q.pend + BEAT;
                s_d.pend = '0;
                s_d.notify_p = 1'b1;
            end
            else
            begin
                s_d.pend = s_q.pend + BEAT;
            end
        end
        // Drain ends once the card has nothing left to hand over
        if (s_q.st == ST_DRAIN_S && s_d.fifo_fill == '0)
        begin
            s_d.st = ST_IDLE_S;
        end

        // ******************************************************************
        // Register writes
        // ******************************************************************
        if (wr_in)
        begin
            case (idx)
                IDX_CARD_LEN:
                begin
                    if (rel > s_d.user_len)
                    begin
                        s_d.release_err = 1'b1;
                    end
                    else
                    begin
                        s_d.user_len = s_d.user_len - rel;
                        s_d.card_len = s_d.card_len + rel;
                        s_d.user_pos = pos_sum;
                    end
                end
                IDX_BUF_LEN: s_d.buf_len = rel;
                IDX_NOTIFY: s_d.notify = rel;
                IDX_PRE_TRIG:
                begin
                    if (step_ok(wdata_in[MEM_W-1:0]) && wdata_in[MEM_W-1:0] >= PRE_MIN
                        && wdata_in[MEM_W-1:0] <= PRE_MAX)
                    begin
                        s_d.pre_trig = wdata_in[MEM_W-1:0];
                    end
                    else
                    begin
                        s_d.limit_err = 1'b1;
                    end
                end
                IDX_POST_TRIG:
                begin
                    if (post_ok(wdata_in[MEM_W-1:0]))
                    begin
                        s_d.post_trig = wdata_in[MEM_W-1:0];
                    end
                    else
                    begin
                        s_d.limit_err = 1'b1;
                    end
                end
                IDX_SEGMENT:
                begin
                    if (step_ok(wdata_in[MEM_W-1:0]) && wdata_in[MEM_W-1:0] >= SEG_MIN
                        && pre_of(wdata_in[MEM_W-1:0], s_q.post_trig) <= PRE_MAX
                        && pre_of(wdata_in[MEM_W-1:0], s_q.post_trig) >= PRE_MIN)
                    begin
                        s_d.segment = wdata_in[MEM_W-1:0];
                        s_d.pre_trig = pre_of(wdata_in[MEM_W-1:0], s_q.post_trig);
                    end
                    else
                    begin
                        s_d.limit_err = 1'b1;
                    end
                end
                IDX_MEM_SIZE: s_d.mem_div = wdata_in[1:0] & MEM_DIV_LOG_MAX;
                IDX_CONTROL:
                begin
                    s_d.mode = wdata_in[CTL_MODE_LSB+1:CTL_MODE_LSB];
                    if (wdata_in[CTL_STOP])
                    begin
                        s_d.st = ST_IDLE_S;
                    end
                    else if (wdata_in[CTL_START])
                    begin
                        s_d.st = ST_MOVE_S;
                        s_d.dir_to_card = wdata_in[CTL_DIR_TO_CARD];
                        s_d.user_len = '0;
                        s_d.pend = '0;
                        s_d.user_pos = '0;
                        s_d.card_len = s_q.buf_len;
                        s_d.fifo_fill = '0;
                        s_d.overrun = 1'b0;
                        s_d.underrun = 1'b0;
                        s_d.release_err = 1'b0;
                        s_d.limit_err = 1'b0;
                    end
                end
                // Ones clear release and limit flags; overrun holds until restart
                IDX_STATUS:
                begin
                    s_d.release_err = s_q.release_err & ~wdata_in[ST_RELEASE_ERR];
                    s_d.limit_err = s_q.limit_err & ~wdata_in[ST_LIMIT_ERR];
                end
                default: ;
            endcase
        end

        // ******************************************************************
        // Register reads
        // ******************************************************************
        if (rd_in)
        begin
            case (idx)
                IDX_USER_LEN: s_d.rdata = DATA_W'(s_q.user_len);
                IDX_USER_POS: s_d.rdata = DATA_W'(s_q.user_pos);
                IDX_FILL_LEVEL: s_d.rdata = DATA_W'(fill_level);
                IDX_BUF_LEN: s_d.rdata = DATA_W'(s_q.buf_len);
                IDX_NOTIFY: s_d.rdata = DATA_W'(s_q.notify);
                IDX_CONTROL: s_d.rdata = DATA_W'({s_q.mode, 1'b0, s_q.dir_to_card, 2'b00});
                IDX_STATUS: s_d.rdata = DATA_W'({s_q.dir_to_card, s_q.limit_err,
                    s_q.release_err, s_q.underrun, s_q.overrun, s_q.st != ST_IDLE_S});
                IDX_PRE_TRIG: s_d.rdata = DATA_W'(s_q.pre_trig);
                IDX_POST_TRIG: s_d.rdata = DATA_W'(s_q.post_trig);
                IDX_SEGMENT: s_d.rdata = DATA_W'(s_q.segment);
                IDX_MEM_SIZE: s_d.rdata = DATA_W'(mem_eff);
                default: s_d.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            s_q <= '0;
            s_q.st <= ST_IDLE_S;
            s_q.post_trig <= POST_MIN;
            s_q.pre_trig <= PRE_MIN;
            s_q.segment <= SEG_MIN;
        end
        else if (ce_in)
        begin
            s_q <= s_d;
        end
    end

    fill_level_calc #(
        .MEM_W(MEM_W)
    ) u_fill (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .ce_in(ce_in),
        .fill_in(s_q.fifo_fill),
        .mem_size_in(mem_eff),
        .level_out(fill_level)
    );

    assign rdata_out = s_q.rdata;
    // Request only while the card owns buffer room and, toward the host, the FIFO is not empty
    assign dma_req_out = (s_q.st != ST_IDLE_S) && beat_ok;
    assign notify_out = s_q.notify_p;
    assign running_out = (s_q.st != ST_IDLE_S);
    assign error_out = s_q.overrun | s_q.underrun | s_q.release_err | s_q.limit_err;

    // ******************************************************************
    // Checks
    // ******************************************************************
    property p_start_counts;
        @(posedge clk_in) disable iff (rst_in)
        (ce_in && wr_in && idx == IDX_CONTROL && wdata_in[CTL_START] && !wdata_in[CTL_STOP])
        |=> (s_q.user_len == '0 && s_q.card_len == $past(s_q.buf_len));
    endproperty
    a_start_counts: assert property (p_start_counts)
        else $error("start did not reset counters");

    property p_oversize;
        @(posedge clk_in) disable iff (rst_in)
        (ce_in && wr_in && idx == IDX_CARD_LEN && rel > s_q.user_len && !dma_done_in)
        |=> (s_q.release_err && s_q.user_pos == $past(s_q.user_pos));
    endproperty
    a_oversize: assert property (p_oversize)
        else $error("oversize release not rejected");

    property p_release;
        @(posedge clk_in) disable iff (rst_in)
        (ce_in && wr_in && idx == IDX_CARD_LEN && rel <= s_q.user_len && !dma_done_in)
        |=> (s_q.card_len == $past(s_q.card_len) + $past(rel));
    endproperty
    a_release: assert property (p_release)
        else $error("release did not credit card");

    property p_wrap;
        @(posedge clk_in) disable iff (rst_in)
        (s_q.buf_len != '0 && s_q.user_pos < s_q.buf_len && !(ce_in && wr_in
            && (idx == IDX_BUF_LEN || idx == IDX_CONTROL)))
        |=> (s_q.user_pos < s_q.buf_len);
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("position beyond buffer length");

    property p_notify_mult;
        @(posedge clk_in) disable iff (rst_in)
        $rose(s_q.notify_p) |-> s_q.pend == '0;
    endproperty
    a_notify_mult: assert property (p_notify_mult)
        else $error("notify left pending bytes");

    property p_read_lat;
        @(posedge clk_in) disable iff (rst_in)
        (ce_in && rd_in && idx == IDX_USER_LEN) |=> rdata_out == DATA_W'($past(s_q.user_len));
    endproperty
    a_read_lat: assert property (p_read_lat)
        else $error("user length read wrong");

    property p_pos_read;
        @(posedge clk_in) disable iff (rst_in)
        (ce_in && rd_in && idx == IDX_USER_POS) |=> rdata_out == DATA_W'($past(s_q.user_pos));
    endproperty
    a_pos_read: assert property (p_pos_read)
        else $error("user position read wrong");

    property p_overrun;
        @(posedge clk_in) disable iff (rst_in)
        (ce_in && running_out && !s_q.dir_to_card && sample_push_in && fifo_full
            && !(wr_in && (idx == IDX_CONTROL || idx == IDX_STATUS)))
        |=> (s_q.overrun && s_q.st != ST_MOVE_S);
    endproperty
    a_overrun: assert property (p_overrun)
        else $error("overrun not flagged");

    property p_post_lim;
        @(posedge clk_in) disable iff (rst_in)
        s_q.post_trig >= POST_MIN && s_q.post_trig <= POST_MAX;
    endproperty
    a_post_lim: assert property (p_post_lim)
        else $error("post trigger out of range");

    property p_pre_lim;
        @(posedge clk_in) disable iff (rst_in)
        s_q.pre_trig <= PRE_MAX && s_q.pre_trig >= PRE_MIN;
    endproperty
    a_pre_lim: assert property (p_pre_lim)
        else $error("pre trigger above limit");

    property p_underrun;
        @(posedge clk_in) disable iff (rst_in)
        (ce_in && running_out && s_q.dir_to_card && sample_pop_in && fifo_empty
            && !(wr_in && idx == IDX_CONTROL))
        |=> (s_q.underrun && !running_out);
    endproperty
    a_underrun: assert property (p_underrun)
        else $error("underrun not flagged");

    property p_rdata_idle;
        @(posedge clk_in) disable iff (rst_in)
        (ce_in && !rd_in) |=> rdata_out == '0;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data outside its cycle");

    c_start: cover property (@(posedge clk_in) $rose(running_out));
    c_notify: cover property (@(posedge clk_in) notify_out);
    c_wrap: cover property (@(posedge clk_in) s_q.user_pos < $past(s_q.user_pos));
    c_overrun: cover property (@(posedge clk_in) $rose(s_q.overrun));
endmodule // ring_buffer_dma_handshake

// ==== hw/ring_dma_pkg.sv ====
package ring_dma_pkg;

    // ******************************************************************
    // Register indices (byte address is four times the index)
    // ******************************************************************
    localparam logic [9:0] IDX_USER_LEN = 10'h0C8;
    localparam logic [9:0] IDX_USER_POS = 10'h0C9;
    localparam logic [9:0] IDX_CARD_LEN = 10'h0CA;
    localparam logic [9:0] IDX_FILL_LEVEL = 10'h0CB;
    localparam logic [9:0] IDX_BUF_LEN = 10'h0CC;
    localparam logic [9:0] IDX_NOTIFY = 10'h0CD;
    localparam logic [9:0] IDX_CONTROL = 10'h0CE;
    localparam logic [9:0] IDX_STATUS = 10'h0CF;
    localparam logic [9:0] IDX_PRE_TRIG = 10'h0D0;
    localparam logic [9:0] IDX_POST_TRIG = 10'h0D1;
    localparam logic [9:0] IDX_SEGMENT = 10'h0D2;
    localparam logic [9:0] IDX_MEM_SIZE = 10'h0D3;

    localparam int ADDR_W = 12;
    localparam int DATA_W = 64;
    localparam int CNT_W = 40;
    localparam int FILL_W = 32;

    // ******************************************************************
    // Control and status bits
    // ******************************************************************
    localparam int CTL_START = 0;
    localparam int CTL_STOP = 1;
    localparam int CTL_DIR_TO_CARD = 2;
    localparam int CTL_MODE_LSB = 4;
    localparam int ST_RUN = 0;
    localparam int ST_OVERRUN = 1;
    localparam int ST_UNDERRUN = 2;
    localparam int ST_RELEASE_ERR = 3;
    localparam int ST_LIMIT_ERR = 4;
    localparam int ST_DIR = 5;

    // FIFO acquisition modes
    localparam logic [1:0] MODE_SINGLE = 2'h0;
    localparam logic [1:0] MODE_MULTI = 2'h1;
    localparam logic [1:0] MODE_GATE = 2'h2;

    // ******************************************************************
    // Length limits, in samples
    // ******************************************************************
    localparam logic [35:0] LEN_STEP = 36'h0_0000_0010;
    localparam logic [35:0] POST_MIN = 36'h0_0000_0010;
    localparam logic [35:0] POST_MAX = 36'h1_FFFF_FFF0;
    localparam logic [35:0] PRE_MIN = 36'h0_0000_0010;
    localparam logic [35:0] PRE_MAX = 36'h0_0000_2000;
    localparam logic [35:0] SEG_MIN = 36'h0_0000_0020;
    localparam logic [35:0] MEM_DEFAULT = 36'h0_8000_0000;
    localparam logic [1:0] MEM_DIV_LOG_MAX = 2'h3;

    // Fill level: permille of full memory, resolved in sixteenths
    localparam int FILL_FRAC_W = 4;
    localparam logic [15:0] PERMILLE_FULL = 16'h03E8;

    typedef enum logic [2:0] {
        ST_IDLE_S = 3'b001,
        ST_MOVE_S = 3'b010,
        ST_DRAIN_S = 3'b100
    } run_state_t;

endpackage

// ==== hw/fill_level_calc.sv ====
`timescale 1ns/1ps
module fill_level_calc
    import ring_dma_pkg::*;
#(
    parameter int MEM_W = 36
)
(
    // Clock
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    // Fill state
    input wire logic [MEM_W-1:0] fill_in,
    input wire logic [MEM_W-1:0] mem_size_in,
    // Result
    output logic [FILL_W-1:0] level_out
);
    typedef struct packed {
        logic [FILL_W-1:0] level;
    } fill_state_t;

    fill_state_t s_q;
    fill_state_t s_d;
    logic [FILL_FRAC_W-1:0] sixteenths;

    // Coarse quantisation matches what the memory controller can resolve
    function automatic logic [FILL_FRAC_W-1:0] to_sixteenths(input logic [MEM_W-1:0] f,
                                                             input logic [MEM_W-1:0] m);
        logic [MEM_W+FILL_FRAC_W-1:0] scaled;
        logic [MEM_W+FILL_FRAC_W-1:0] q;
        scaled = {f, {FILL_FRAC_W{1'b0}}};
        q = (m == '0) ? '0 : scaled / {{FILL_FRAC_W{1'b0}}, m};
        to_sixteenths = (q[MEM_W+FILL_FRAC_W-1:FILL_FRAC_W] != '0) ? '1 : q[FILL_FRAC_W-1:0];
    endfunction

    always_comb
    begin
        s_d = s_q;
        sixteenths = to_sixteenths(fill_in, mem_size_in);
        if (fill_in >= mem_size_in && mem_size_in != '0)
        begin
            s_d.level = {16'h0000, PERMILLE_FULL};
        end
        else
        begin
            s_d.level = {16'h0000, 16'((32'(sixteenths) * 32'(PERMILLE_FULL)) >> FILL_FRAC_W)};
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            s_q <= '0;
        end
        else if (ce_in)
        begin
            s_q <= s_d;
        end
    end

    assign level_out = s_q.level;

    property p_fill_bound;
        @(posedge clk_in) disable iff (rst_in)
        level_out <= 32'(PERMILLE_FULL);
    endproperty
    a_fill_bound: assert property (p_fill_bound)
        else $error("fill level above full scale");
endmodule // fill_level_calc

// ==== tb/dma_beat_model.sv ====
`timescale 1ns/1ps
module dma_beat_model (
    // Clock and control
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic en_in,
    input wire logic [2:0] wait_in,
    // Beat handshake
    input wire logic dma_req_in,
    output logic dma_done_out
);
    logic [2:0] cnt_q;
    // host region takes one beat per grant
    always_ff @(posedge clk_in)
    begin
        dma_done_out <= 1'b0;
        // Counter restarts after every beat so a stale grant is never reused
        if (rst_in || !en_in || !dma_req_in || dma_done_out)
            cnt_q <= 3'h0;
        else if (cnt_q >= wait_in)
        begin
            dma_done_out <= 1'b1;
            cnt_q <= 3'h0;
        end
        else
            cnt_q <= cnt_q + 3'h1;
    end
endmodule // dma_beat_model

// ==== tb/ring_buffer_dma_handshake_test.sv ====
`timescale 1ns/1ps
module ring_buffer_dma_handshake_test;
    import ring_dma_pkg::*;
    localparam logic [35:0] MEM = 36'h0_0000_0040;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [11:0] addr = 12'h000;
    logic [63:0] wdata = 64'h0;
    logic wr = 1'b0;
    logic rd_s = 1'b0;
    logic push = 1'b0;
    logic pop = 1'b0;
    logic dma_en = 1'b0;
    logic [2:0] dly = 3'h0;
    logic [63:0] rdata, v, u, p;
    logic req, done, notify, running, err;
    int seed, n_errors, checks_done, cycles, n_notify, i;
    ring_buffer_dma_handshake #(.MEM_SAMPLES(MEM)) dut (.clk_in(clk_in), .rst_in(rst_in),
        .ce_in(1'b1), .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd_s),
        .rdata_out(rdata), .sample_push_in(push), .sample_pop_in(pop), .dma_req_out(req),
        .dma_done_in(done), .notify_out(notify), .running_out(running), .error_out(err));
    dma_beat_model far (.clk_in(clk_in), .rst_in(rst_in), .en_in(dma_en), .wait_in(dly),
        .dma_req_in(req), .dma_done_out(done));
    initial
    begin
        forever #50 clk_in = ~clk_in;
    end
    // ******************
    // Bus and checks
    // ******************
    task automatic wreg(input logic [9:0] idx, input logic [63:0] d);
        @(posedge clk_in);
        addr <= {idx, 2'b00};
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_in);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [9:0] idx, output logic [63:0] d);
        @(posedge clk_in);
        addr <= {idx, 2'b00};
        rd_s <= 1'b1;
        @(posedge clk_in);
        rd_s <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        checks_done++;
        if (got !== exp)
        begin
            n_errors++;
            $display("FAIL %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic feed(input int n);
        repeat (n) @(posedge clk_in) push <= 1'b1;
        @(posedge clk_in) push <= 1'b0;
    endtask
    task automatic results;
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(posedge clk_in)
    begin
        cycles++;
        dly <= 3'($random(seed));
        if (notify === 1'b1)
            n_notify++;
        // Ceiling well above the under one thousand cycles the sequence needs
        if (cycles == 20000)
        begin
            n_errors++;
            results;
        end
    end
    // ******************
    // Main sequence
    // ******************
    initial
    begin
        seed = 29;
        repeat (6) @(posedge clk_in);
        rst_in <= 1'b0;
        rreg(10'h3FF, v); chk("unmapped", 64'h0, v);
        for (i = 0; i < 4; i++)
        begin
            wreg(IDX_MEM_SIZE, 64'(i));
            rreg(IDX_MEM_SIZE, v); chk("mem size", 64'(MEM >> i), v);
        end
        wreg(IDX_MEM_SIZE, 64'h0);
        for (i = 0; i < 6; i++)
        begin
            u = (i == 0) ? 64'h10 : (i == 1) ? 64'(POST_MAX) : 64'(($random(seed) & 'hFFFF0) | 16);
            wreg(IDX_POST_TRIG, u);
            rreg(IDX_POST_TRIG, v); chk("post", u, v);
        end
        wreg(IDX_POST_TRIG, 64'h8);
        rreg(IDX_STATUS, v); chk("post limit", 64'h1, 64'(v[ST_LIMIT_ERR]));
        wreg(IDX_POST_TRIG, 64'h10);
        wreg(IDX_SEGMENT, 64'h30);
        rreg(IDX_PRE_TRIG, v); chk("pre", 64'h20, v);
        wreg(IDX_STATUS, 64'h18);
        wreg(IDX_SEGMENT, 64'h2020);
        rreg(IDX_PRE_TRIG, v); chk("pre kept", 64'h20, v);
        rreg(IDX_STATUS, v); chk("seg limit", 64'h1, 64'(v[ST_LIMIT_ERR]));
        wreg(IDX_STATUS, 64'h18);
        wreg(IDX_BUF_LEN, 64'h40);
        wreg(IDX_NOTIFY, 64'h10);
        wreg(IDX_CONTROL, 64'h11);
        rreg(IDX_USER_LEN, v); chk("start user", 64'h0, v);
        chk("running", 64'h1, 64'(running));
        feed(32);
        rreg(IDX_FILL_LEVEL, v); chk("fill", 64'd500, v);
        dma_en <= 1'b1;
        repeat (200) @(posedge clk_in);
        rreg(IDX_USER_LEN, u); chk("user step", 64'h0, u % 16);
        chk("notified", 64'h1, 64'(n_notify > 0 && u != 0));
        wreg(IDX_CARD_LEN, u);
        rreg(IDX_USER_POS, v); chk("pos", u % 64, v);
        wreg(IDX_CARD_LEN, 64'h1000);
        rreg(IDX_STATUS, v); chk("oversize", 64'h1, 64'(v[ST_RELEASE_ERR]));
        feed(32);
        repeat (200) @(posedge clk_in);
        rreg(IDX_USER_POS, p);
        rreg(IDX_USER_LEN, u);
        wreg(IDX_CARD_LEN, u);
        rreg(IDX_USER_POS, v); chk("wrap pos", (p + u) % 64, v);
        dma_en <= 1'b0;
        feed(80);
        rreg(IDX_STATUS, v); chk("overrun", 64'h1, 64'(v[ST_OVERRUN]));
        chk("error", 64'h1, 64'(err));
        wreg(IDX_CONTROL, 64'h2);
        wreg(IDX_CONTROL, 64'h5);
        wreg(IDX_CARD_LEN, 64'h0);
        @(posedge clk_in) pop <= 1'b1;
        @(posedge clk_in) pop <= 1'b0;
        rreg(IDX_STATUS, v); chk("underrun", 64'h4, v & 64'hD);
        chk("req idle", 64'h0, 64'(req));
        results;
    end
endmodule // ring_buffer_dma_handshake_test
